// ---- bench/pitic_partner.sv ----
// partner: PCI request source and observer of the window's processor-bus request and keep-hit pulses
// assumes the window answers one cycle after a claimed request
`timescale 1ns/100ps
module pitic_partner (
	input  wire logic        clk,          // bench clock
	output logic             pci_valid,    // request pulse
	output logic [31:0]      pci_addr,     // request address
	output logic             pci_write,    // 1 write, 0 read
	output logic             pci_multiple, // multiple-read request
	output logic [31:0]      pci_wdata,    // write data
	input  wire logic        pci_claim,    // claim from window
	input  wire logic        pb_req,       // processor-bus cycle pulse
	input  wire logic        pb_keep_hit   // read served from kept data
);
	initial begin
		pci_valid = 1'h0;
		pci_addr = 32'h0000_0000;
		pci_write = 1'h0;
		pci_multiple = 1'h0;
		pci_wdata = 32'h0000_0000;
	end

	// one request; returns the claim and the answer a cycle later
	task automatic issue(input logic [31:0] a, input logic w, input logic m,
		input logic [31:0] d, output logic cl, output logic rq,
		output logic hit);
		pci_addr <= a;
		pci_write <= w;
		pci_multiple <= m;
		pci_wdata <= d;
		pci_valid <= 1'h1;
		@(negedge clk);
		cl = pci_claim;
		@(posedge clk);
		pci_valid <= 1'h0;
		// released lines must not keep showing the last value
		pci_addr <= ~a;
		pci_wdata <= ~d;
		@(negedge clk);
		rq = pb_req;
		hit = pb_keep_hit;
		@(posedge clk);
	endtask : issue
endmodule : pitic_partner

// ---- bench/pitic_window_tb.sv ----
// bench: drives the window core over Avalon-MM and through the partner
// assumes pitic_pkg and pitic_partner are compiled before this file
`timescale 1ns/100ps
module pitic_window_tb;
	localparam logic [11:0] CTL = pitic_pkg::CTL_OFS;
	localparam logic [11:0] TAD = pitic_pkg::TRANSLATION_BASE_OFS;
	localparam logic [11:0] BAS = pitic_pkg::BASE_OFS;
	logic        clk;
	logic        resetn;
	logic [11:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        pci_valid;
	logic [31:0] pci_addr;
	logic        pci_write;
	logic        pci_multiple;
	logic [31:0] pci_wdata;
	logic        pci_claim;
	logic        pb_req;
	logic        pb_keep_hit;
	logic [31:0] pb_addr;
	logic [4:0]  pbus_transfer_type;
	logic        pbus_global_n;
	logic        pbus_inhibit_n;
	logic [7:0]  pb_fetch_bytes;
	logic [31:0] pb_wdata;
	logic        cl;
	logic        rq;
	logic        hit;
	logic [31:0] rd;
	int          n_errors = 0;
	int          tests_run = 0;

	pitic_window uut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pci_valid(pci_valid), .pci_addr(pci_addr), .pci_write(pci_write),
		.pci_multiple(pci_multiple), .pci_wdata(pci_wdata),
		.pci_claim(pci_claim), .pb_req(pb_req), .pb_keep_hit(pb_keep_hit),
		.pb_addr(pb_addr), .pbus_transfer_type(pbus_transfer_type),
		.pbus_global_n(pbus_global_n), .pbus_inhibit_n(pbus_inhibit_n),
		.pb_fetch_bytes(pb_fetch_bytes), .pb_wdata(pb_wdata));

	pitic_partner p (.clk(clk), .pci_valid(pci_valid), .pci_addr(pci_addr),
		.pci_write(pci_write), .pci_multiple(pci_multiple),
		.pci_wdata(pci_wdata), .pci_claim(pci_claim), .pb_req(pb_req),
		.pb_keep_hit(pb_keep_hit));

	always #50 clk = ~clk;

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic chkb(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chkb

	// one bus cycle; read data lands in rd
	task automatic av(input logic w, input logic [11:0] a, input logic [31:0] d);
		int   n;
		logic stuck;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'h0 && n < 20);
		stuck = (avs_waitrequest !== 1'h0);
		rd = avs_readdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clk);
		if (stuck) begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, 1'h1, 1'h0);
			end_of_test();
		end
	endtask : av

	// enable and bar set, read type 0x0b, write type 0x06
	function automatic logic [31:0] mk(input logic tr, input logic [3:0] sz,
		input logic [1:0] gc, input logic kp, input logic [1:0] od,
		input logic al, input logic [2:0] pf);
		return {3'h7, 1'h0, sz, 3'h0, 5'h0b, gc, 1'h0, 5'h06, kp, od, al,
			1'h0, pf} & {1'h1, tr, 30'h3fff_ffff};
	endfunction : mk

	task automatic t_reset;
		av(1'h0, CTL, 32'h0000_0000);
		chk(rd, 32'h000a_0240);
		av(1'h0, TAD, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk({27'h0, pbus_transfer_type}, 32'h0000_000a);
		$display("test reset done");
	endtask : t_reset

	task automatic t_bar;
		av(1'h1, BAS, 32'h1234_0000);
		av(1'h0, BAS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		p.issue(32'h1234_5000, 1'h0, 1'h0, 32'h0, cl, rq, hit);
		chkb(cl, 1'h0);
		av(1'h1, CTL, 32'h200a_0240);
		avs_byteenable <= 4'h3;
		av(1'h1, BAS, 32'h1234_0000);
		avs_byteenable <= 4'hf;
		av(1'h0, BAS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		av(1'h1, BAS, 32'h1234_0000);
		av(1'h0, BAS, 32'h0000_0000);
		chk(rd, 32'h1234_0000);
		av(1'h0, CTL, 32'h0000_0000);
		chkb(rd[31], 1'h1);
		p.issue(32'h1234_5000, 1'h0, 1'h0, 32'h0, cl, rq, hit);
		chkb(cl, 1'h1);
		av(1'h1, BAS, 32'h0000_0000);
		av(1'h0, CTL, 32'h0000_0000);
		chkb(rd[31], 1'h0);
		av(1'h1, BAS, 32'h1234_0000);
		$display("test bar done");
	endtask : t_bar

	task automatic t_claim;
		av(1'h1, CTL, mk(1'h0, 4'h0, 2'h0, 1'h0, 2'h0, 1'h0, 3'h0));
		p.issue(32'h1234_5008, 1'h0, 1'h0, 32'h0, cl, rq, hit);
		chkb(rq, 1'h1);
		chk(pb_addr, 32'h1234_5008);
		chk({27'h0, pbus_transfer_type}, 32'h0000_000b);
		chkb(pbus_global_n, 1'h0);
		chkb(pbus_inhibit_n, 1'h0);
		av(1'h1, CTL, mk(1'h0, 4'h1, 2'h3, 1'h0, 2'h0, 1'h0, 3'h0));
		p.issue(32'h1235_5000, 1'h1, 1'h0, 32'h1122_3344, cl, rq, hit);
		chkb(cl, 1'h1);
		chk({27'h0, pbus_transfer_type}, 32'h0000_0006);
		chkb(pbus_global_n, 1'h1);
		chkb(pbus_inhibit_n, 1'h1);
		chk(pb_wdata, 32'h1122_3344);
		for (int s = 0; s < 5; s++) begin
			av(1'h1, CTL, mk(1'h0, 4'(s), 2'h0, 1'h0, 2'h2, 1'h0, 3'h0));
			p.issue(32'h1234_5000 ^ (32'h1 << (16 + s)), 1'h0, 1'h0, 32'h0,
				cl, rq, hit);
			chkb(cl, 1'h0);
			p.issue(32'h1234_5000 ^ (32'h1 << (15 + s)), 1'h0, 1'h0, 32'h0,
				cl, rq, hit);
			chkb(cl, 1'h1);
		end
		$display("test claim done");
	endtask : t_claim

	task automatic t_trans;
		av(1'h1, TAD, 32'habcd_0000);
		av(1'h0, TAD, 32'h0000_0000);
		chk(rd, 32'habcd_0000);
		av(1'h1, CTL, mk(1'h1, 4'h0, 2'h0, 1'h0, 2'h2, 1'h0, 3'h0));
		p.issue(32'h1234_5010, 1'h1, 1'h0, 32'h1122_3344, cl, rq, hit);
		chk(pb_addr, 32'habcd_5010);
		chk(pb_wdata, 32'h4433_2211);
		p.issue(32'h1234_0010, 1'h1, 1'h0, 32'h1122_3344, cl, rq, hit);
		chk(pb_addr, 32'h1234_0010);
		chk(pb_wdata, 32'h1122_3344);
		$display("test translation done");
	endtask : t_trans

	task automatic t_fetch;
		for (int c = 0; c < 8; c++) begin
			av(1'h1, CTL, mk(1'h0, 4'h0, 2'h0, 1'h0, 2'h2, 1'h0, 3'(c)));
			p.issue(32'h1234_5000, 1'h0, 1'h1, 32'h0, cl, rq, hit);
			chk({24'h0, pb_fetch_bytes}, c < 5 ? 32'h8 << c : 32'h8);
		end
		av(1'h1, CTL, mk(1'h0, 4'h0, 2'h0, 1'h0, 2'h2, 1'h0, 3'h3));
		p.issue(32'h1234_5000, 1'h0, 1'h0, 32'h0, cl, rq, hit);
		chk({24'h0, pb_fetch_bytes}, 32'h0000_0008);
		av(1'h1, CTL, mk(1'h0, 4'h0, 2'h0, 1'h0, 2'h2, 1'h1, 3'h3));
		p.issue(32'h1234_5000, 1'h0, 1'h0, 32'h0, cl, rq, hit);
		chk({24'h0, pb_fetch_bytes}, 32'h0000_0040);
		p.issue(32'h1234_0020, 1'h0, 1'h1, 32'h0, cl, rq, hit);
		chk({24'h0, pb_fetch_bytes}, 32'h0000_0008);
		$display("test fetch done");
	endtask : t_fetch

	task automatic t_keep;
		av(1'h1, CTL, mk(1'h0, 4'h0, 2'h0, 1'h1, 2'h2, 1'h0, 3'h1));
		p.issue(32'h1234_6000, 1'h0, 1'h1, 32'h0, cl, rq, hit);
		chkb(rq, 1'h1);
		p.issue(32'h1234_6004, 1'h0, 1'h1, 32'h0, cl, rq, hit);
		chkb(hit, 1'h1);
		chkb(rq, 1'h0);
		p.issue(32'h1234_600c, 1'h0, 1'h1, 32'h0, cl, rq, hit);
		chkb(rq, 1'h1);
		p.issue(32'h1234_6010, 1'h0, 1'h1, 32'h0, cl, rq, hit);
		p.issue(32'h1234_6014, 1'h0, 1'h1, 32'h0, cl, rq, hit);
		p.issue(32'h1234_6018, 1'h0, 1'h1, 32'h0, cl, rq, hit);
		chkb(hit, 1'h1);
		p.issue(32'h1234_601c, 1'h0, 1'h1, 32'h0, cl, rq, hit);
		chkb(rq, 1'h1);
		p.issue(32'h1234_0000, 1'h0, 1'h1, 32'h0, cl, rq, hit);
		p.issue(32'h1234_0004, 1'h0, 1'h1, 32'h0, cl, rq, hit);
		chkb(hit, 1'h0);
		$display("test keep done");
	endtask : t_keep

	initial begin
		clk = 1'h0;
		resetn = 1'h0;
		avs_address = 12'h000;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hf;
		repeat (3) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		t_reset();
		t_bar();
		t_claim();
		t_trans();
		t_fetch();
		t_keep();
		end_of_test();
	end
endmodule : pitic_window_tb

// ---- core/pitic_pkg.sv ----
// package: register map, field layout and reset values of the messaging
// window control; shared by the window core and its bench
package pitic_pkg;
	// register byte addresses on the control bus
	localparam logic [11:0] CTL_OFS      = 12'h500;
	localparam logic [11:0] TRANSLATION_BASE_OFS    = 12'h504;
	localparam logic [11:0] BASE_OFS     = 12'h510;
	// messaging_window_control field positions
	localparam int          WIN_EN_BIT   = 31;
	localparam int          TRANS_EN_BIT = 30;
	localparam int          BAR_EN_BIT   = 29;
	localparam int          SIZE_LSB     = 24;
	localparam int          RTYPE_LSB    = 16;
	localparam int          GBL_BIT      = 15;
	localparam int          CI_BIT       = 14;
	localparam int          WTYPE_LSB    = 8;
	localparam int          KEEP_BIT     = 7;
	localparam int          ORDER_LSB    = 5;
	localparam int          ALIAS_BIT    = 4;
	localparam int          PREF_LSB     = 0;
	// translation base and window base sit in the upper half word
	localparam int          UPPER_LSB    = 16;
	// reset values
	localparam logic [4:0]  RTYPE_RST    = 5'h0a;
	localparam logic [4:0]  WTYPE_RST    = 5'h02;
	localparam logic [1:0]  ORDER_RST    = 2'h2;
	localparam logic [3:0]  SIZE_RST     = 4'h0;
	localparam logic [2:0]  PREF_RST     = 3'h0;
	localparam logic [15:0] UPPER_RST    = 16'h0000;
	// shell region is the lowest 4 Kbytes of the window
	localparam int          SHELL_BITS   = 12;
	// fetch sizes
	localparam logic [7:0]  FETCH_MIN    = 8'h08;
	localparam logic [2:0]  PREF_MAX     = 3'h4;
	// byte-order modes
	typedef enum logic [1:0] {
		PITIC_ORD_LITTLE = 2'b00,
		PITIC_ORD_PLE    = 2'b01,
		PITIC_ORD_BIG    = 2'b10,
		PITIC_ORD_TRUE   = 2'b11
	} pitic_order_e;
endpackage : pitic_pkg

// ---- core/pitic_window.sv ----
// window core: control registers on Avalon-MM, claim decode, address
// substitution, processor-bus attributes, byte order and read keep.
// assumes a PCI front end that presents one decoded request per pulse.
//
// Overview of operation
// - lowest 4 Kbytes form shell, frames above
// - every claimed access goes to processor bus unless served from kept data
// - shell ignores translation, read keep, byte order
// - shell reads always prefetch exactly 8 bytes
// - enable reset 0, set/cleared by base writes
// - translation enable substitutes upper address bits
// - base register hidden and read-only when disabled
// - size is 64K doubled per code step
// - reads drive programmed read type code
// - writes drive programmed write type code
// - global and inhibit select drive low-active attributes
// - read keep serves sequential reads, drops on mismatch
// - byte order resets big-endian, four modes
// - prefetch size code sets multiple-read fetch length
// - prefetch codes 8 to 128 bytes, rest reserved
// - translation base 16 bits, reset to zero
`timescale 1ns/100ps
module pitic_window (
	input  wire logic        clk,              // 10 MHz clock
	input  wire logic        resetn,           // primary reset, sync, low
	input  wire logic [11:0] avs_address,      // byte address
	input  wire logic        avs_read,         // read request
	input  wire logic        avs_write,        // write request
	input  wire logic [31:0] avs_writedata,    // write data
	input  wire logic [3:0]  avs_byteenable,   // byte lanes
	output logic      [31:0] avs_readdata,     // read data
	output logic             avs_waitrequest,  // stall
	input  wire logic        pci_valid,        // decoded request pulse
	input  wire logic [31:0] pci_addr,         // PCI address
	input  wire logic        pci_write,        // 1 write, 0 read
	input  wire logic        pci_multiple,     // read is Memory Read Multiple
	input  wire logic [31:0] pci_wdata,        // PCI write data
	output logic             pci_claim,        // window claims request
	output logic             pb_req,           // processor-bus cycle pulse
	output logic             pb_keep_hit,      // read served from kept data
	output logic [31:0]      pb_addr,          // processor-bus address
	output logic [4:0]       pbus_transfer_type, // transfer type lines
	output logic             pbus_global_n,    // global, low active
	output logic             pbus_inhibit_n,   // cache inhibit, low active
	output logic [7:0]       pb_fetch_bytes,   // read fetch length
	output logic [31:0]      pb_wdata          // converted write data
);
	logic        window_enable, next_window_enable;
	logic        translation_enable, next_translation_enable;
	logic        bar_enable, next_bar_enable;
	logic [3:0]  window_size_code, next_window_size_code;
	logic [4:0]  read_type_code, next_read_type_code;
	logic [4:0]  write_type_code, next_write_type_code;
	logic        global_attr_select, next_global_attr_select;
	logic        cache_inhibit_select, next_cache_inhibit_select;
	logic        read_keep_enable, next_read_keep_enable;
	logic [1:0]  byte_order, next_byte_order;
	logic        read_alias_enable, next_read_alias_enable;
	logic [2:0]  prefetch_size_code, next_prefetch_size_code;
	logic [15:0] translation_base, next_translation_base;
	logic [15:0] window_base, next_window_base;
	logic        ack, next_ack;
	logic [31:0] rdata, next_rdata;
	logic        keep_valid, next_keep_valid;
	logic [31:0] keep_addr, next_keep_addr;
	logic [7:0]  keep_left, next_keep_left;
	logic        next_pb_req, next_pb_keep_hit;
	logic [31:0] next_pb_addr, next_pb_wdata;
	logic [4:0]  next_pb_type;
	logic        next_pb_global_n, next_pb_inhibit_n;
	logic [7:0]  next_pb_fetch;
	logic        bus_req, wr_take;
	logic [15:0] size_mask;
	logic        in_shell, is_hit;
	logic [31:0] ctl_word;
	logic [7:0]  prog_fetch;

	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack;
	assign avs_readdata    = rdata;
	assign wr_take         = avs_write & ack;
	assign size_mask       = 16'hffff << window_size_code;
	assign pci_claim       = pci_valid & window_enable
		& (((pci_addr[31:16] ^ window_base) & size_mask) == 16'h0000);
	assign in_shell        = ((pci_addr[31:16] & ~size_mask) == 16'h0000)
		& (pci_addr[15:pitic_pkg::SHELL_BITS] == '0);
	assign prog_fetch      = (prefetch_size_code > pitic_pkg::PREF_MAX)
		? pitic_pkg::FETCH_MIN
		: pitic_pkg::FETCH_MIN << prefetch_size_code;
	assign is_hit          = ~pci_write & ~in_shell & read_keep_enable
		& keep_valid & (pci_addr == keep_addr);

	always_comb begin
		ctl_word = 32'h0000_0000;
		ctl_word[pitic_pkg::WIN_EN_BIT]   = window_enable;
		ctl_word[pitic_pkg::TRANS_EN_BIT] = translation_enable;
		ctl_word[pitic_pkg::BAR_EN_BIT]   = bar_enable;
		ctl_word[pitic_pkg::SIZE_LSB+:4]  = window_size_code;
		ctl_word[pitic_pkg::RTYPE_LSB+:5] = read_type_code;
		ctl_word[pitic_pkg::GBL_BIT]      = global_attr_select;
		ctl_word[pitic_pkg::CI_BIT]       = cache_inhibit_select;
		ctl_word[pitic_pkg::WTYPE_LSB+:5] = write_type_code;
		ctl_word[pitic_pkg::KEEP_BIT]     = read_keep_enable;
		ctl_word[pitic_pkg::ORDER_LSB+:2] = byte_order;
		ctl_word[pitic_pkg::ALIAS_BIT]    = read_alias_enable;
		ctl_word[pitic_pkg::PREF_LSB+:3]  = prefetch_size_code;
	end

	// register file: answer one cycle after the request appears
	always_comb begin
		next_ack                  = bus_req & ~ack;
		next_rdata                = rdata;
		next_window_enable        = window_enable;
		next_translation_enable   = translation_enable;
		next_bar_enable           = bar_enable;
		next_window_size_code     = window_size_code;
		next_read_type_code       = read_type_code;
		next_write_type_code      = write_type_code;
		next_global_attr_select   = global_attr_select;
		next_cache_inhibit_select = cache_inhibit_select;
		next_read_keep_enable     = read_keep_enable;
		next_byte_order           = byte_order;
		next_read_alias_enable    = read_alias_enable;
		next_prefetch_size_code   = prefetch_size_code;
		next_translation_base     = translation_base;
		next_window_base          = window_base;
		if (avs_read & ~ack) begin
			unique case (avs_address)
				pitic_pkg::CTL_OFS:   next_rdata = ctl_word;
				pitic_pkg::TRANSLATION_BASE_OFS: next_rdata = {translation_base, 16'h0000};
				pitic_pkg::BASE_OFS:  next_rdata = bar_enable
					? {window_base, 16'h0000} : 32'h0000_0000;
				default:              next_rdata = 32'h0000_0000;
			endcase
		end
		if (wr_take && avs_address == pitic_pkg::CTL_OFS) begin
			if (avs_byteenable[3]) begin
				next_window_enable      = avs_writedata[pitic_pkg::WIN_EN_BIT];
				next_translation_enable = avs_writedata[pitic_pkg::TRANS_EN_BIT];
				next_bar_enable         = avs_writedata[pitic_pkg::BAR_EN_BIT];
				next_window_size_code   = avs_writedata[pitic_pkg::SIZE_LSB+:4];
			end
			if (avs_byteenable[2])
				next_read_type_code = avs_writedata[pitic_pkg::RTYPE_LSB+:5];
			if (avs_byteenable[1]) begin
				next_global_attr_select   = avs_writedata[pitic_pkg::GBL_BIT];
				next_cache_inhibit_select = avs_writedata[pitic_pkg::CI_BIT];
				next_write_type_code      = avs_writedata[pitic_pkg::WTYPE_LSB+:5];
			end
			if (avs_byteenable[0]) begin
				next_read_keep_enable   = avs_writedata[pitic_pkg::KEEP_BIT];
				next_byte_order         = avs_writedata[pitic_pkg::ORDER_LSB+:2];
				next_read_alias_enable  = avs_writedata[pitic_pkg::ALIAS_BIT];
				next_prefetch_size_code = avs_writedata[pitic_pkg::PREF_LSB+:3];
			end
		end
		if (wr_take && avs_address == pitic_pkg::TRANSLATION_BASE_OFS) begin
			if (avs_byteenable[3])
				next_translation_base[15:8] = avs_writedata[31:24];
			if (avs_byteenable[2])
				next_translation_base[7:0] = avs_writedata[23:16];
		end
		if (wr_take && avs_address == pitic_pkg::BASE_OFS && bar_enable
			&& avs_byteenable[3:2] == 2'b11) begin
			next_window_base   = avs_writedata[31:16];
			next_window_enable = avs_writedata[31:16] != 16'h0000;
		end
	end

	// processor-bus side: one registered cycle per claimed request not served from kept data
	always_comb begin
		next_pb_req       = 1'b0;
		next_pb_keep_hit  = 1'b0;
		next_pb_addr      = pb_addr;
		next_pb_wdata     = pb_wdata;
		next_pb_type      = pbus_transfer_type;
		next_pb_global_n  = pbus_global_n;
		next_pb_inhibit_n = pbus_inhibit_n;
		next_pb_fetch     = pb_fetch_bytes;
		next_keep_valid   = keep_valid;
		next_keep_addr    = keep_addr;
		next_keep_left    = keep_left;
		if (pci_claim) begin
			next_pb_addr = pci_addr;
			if (translation_enable & ~in_shell)
				next_pb_addr[31:16] = (translation_base & size_mask)
					| (pci_addr[31:16] & ~size_mask);
			next_pb_wdata = pci_wdata;
			if (~in_shell) begin
				unique case (pitic_pkg::pitic_order_e'(byte_order))
					pitic_pkg::PITIC_ORD_BIG: next_pb_wdata = {pci_wdata[7:0],
						pci_wdata[15:8], pci_wdata[23:16], pci_wdata[31:24]};
					pitic_pkg::PITIC_ORD_PLE:
						next_pb_addr[2] = ~next_pb_addr[2];
					pitic_pkg::PITIC_ORD_LITTLE,
					pitic_pkg::PITIC_ORD_TRUE: next_pb_wdata = pci_wdata;
				endcase
			end
			next_pb_type = pci_write ? write_type_code
				: read_type_code;
			next_pb_global_n  = global_attr_select;
			next_pb_inhibit_n = cache_inhibit_select;
			if (in_shell | pci_write)
				next_pb_fetch = pitic_pkg::FETCH_MIN;
			else if (pci_multiple | read_alias_enable)
				next_pb_fetch = prog_fetch;
			else
				next_pb_fetch = pitic_pkg::FETCH_MIN;
			if (is_hit) begin
				next_pb_keep_hit = 1'b1;
				next_keep_addr   = pci_addr + 32'h0000_0004;
				next_keep_left   = keep_left - 8'h04;
			end else begin
				next_pb_req = 1'b1;
				if (~pci_write) begin
					next_keep_valid = read_keep_enable & ~in_shell;
					next_keep_addr  = pci_addr + 32'h0000_0004;
					next_keep_left  = next_pb_fetch - 8'h04;
				end
			end
			// kept data runs out once the last fetched word is served
			if (is_hit && keep_left == 8'h04)
				next_keep_valid = 1'b0;
		end
		if (~read_keep_enable)
			next_keep_valid = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ack                  <= 1'b0;
			rdata                <= 32'h0000_0000;
			window_enable        <= 1'b0;
			translation_enable   <= 1'b0;
			bar_enable           <= 1'b0;
			window_size_code     <= pitic_pkg::SIZE_RST;
			read_type_code       <= pitic_pkg::RTYPE_RST;
			write_type_code      <= pitic_pkg::WTYPE_RST;
			global_attr_select   <= 1'b0;
			cache_inhibit_select <= 1'b0;
			read_keep_enable     <= 1'b0;
			byte_order           <= pitic_pkg::ORDER_RST;
			read_alias_enable    <= 1'b0;
			prefetch_size_code   <= pitic_pkg::PREF_RST;
			translation_base     <= pitic_pkg::UPPER_RST;
			window_base          <= pitic_pkg::UPPER_RST;
			keep_valid           <= 1'b0;
			keep_addr            <= 32'h0000_0000;
			keep_left            <= 8'h00;
			pb_req               <= 1'b0;
			pb_keep_hit          <= 1'b0;
			pb_addr              <= 32'h0000_0000;
			pb_wdata             <= 32'h0000_0000;
			pbus_transfer_type   <= pitic_pkg::RTYPE_RST;
			pbus_global_n        <= 1'b1;
			pbus_inhibit_n       <= 1'b1;
			pb_fetch_bytes       <= pitic_pkg::FETCH_MIN;
		end else begin
			ack                  <= next_ack;
			rdata                <= next_rdata;
			window_enable        <= next_window_enable;
			translation_enable   <= next_translation_enable;
			bar_enable           <= next_bar_enable;
			window_size_code     <= next_window_size_code;
			read_type_code       <= next_read_type_code;
			write_type_code      <= next_write_type_code;
			global_attr_select   <= next_global_attr_select;
			cache_inhibit_select <= next_cache_inhibit_select;
			read_keep_enable     <= next_read_keep_enable;
			byte_order           <= next_byte_order;
			read_alias_enable    <= next_read_alias_enable;
			prefetch_size_code   <= next_prefetch_size_code;
			translation_base     <= next_translation_base;
			window_base          <= next_window_base;
			keep_valid           <= next_keep_valid;
			keep_addr            <= next_keep_addr;
			keep_left            <= next_keep_left;
			pb_req               <= next_pb_req;
			pb_keep_hit          <= next_pb_keep_hit;
			pb_addr              <= next_pb_addr;
			pb_wdata             <= next_pb_wdata;
			pbus_transfer_type   <= next_pb_type;
			pbus_global_n        <= next_pb_global_n;
			pbus_inhibit_n       <= next_pb_inhibit_n;
			pb_fetch_bytes       <= next_pb_fetch;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_claim_needs_enable: assert property (
		pci_claim |-> window_enable && ((pci_addr[31:16] ^ window_base)
			& (16'hffff << window_size_code)) == 16'h0000)
		else $error("claim without enable or base match");
	chk_claim_reaches_pb: assert property (
		pci_claim |=> (pb_req ^ pb_keep_hit))
		else $error("claimed request not forwarded");
	chk_read_type_drive: assert property (
		pci_claim && !pci_write |=> pbus_transfer_type == $past(read_type_code))
		else $error("read type code not driven");
	chk_write_type_drive: assert property (
		pci_claim && pci_write |=> pbus_transfer_type == $past(write_type_code))
		else $error("write type code not driven");
	chk_attr_levels: assert property (
		pci_claim |=> pbus_global_n == $past(global_attr_select)
			&& pbus_inhibit_n == $past(cache_inhibit_select))
		else $error("attribute levels wrong");
	chk_shell_fetch_eight: assert property (
		pci_claim && in_shell |=> pb_fetch_bytes == 8'h08 && !pb_keep_hit)
		else $error("shell read fetch not 8 bytes");
	chk_shell_no_subst: assert property (
		pci_claim && in_shell |=> pb_addr == $past(pci_addr))
		else $error("shell address altered");
	chk_base_hidden: assert property (
		avs_read && !ack && avs_address == pitic_pkg::BASE_OFS && !bar_enable
			|=> avs_readdata == 32'h0000_0000)
		else $error("base register visible while disabled");
	chk_bus_answer: assert property (
		bus_req && !ack |=> !avs_waitrequest)
		else $error("bus answer late");
	chk_alias_fetch: assert property (
		pci_claim && !pci_write && !in_shell && !pci_multiple && !read_alias_enable
			|=> pb_fetch_bytes == 8'h08)
		else $error("plain read fetch not 8 bytes");

	cov_keep_hit:    cover property (pb_keep_hit);
	cov_translated:  cover property (pci_claim && translation_enable && !in_shell);
	cov_shell_read:  cover property (pci_claim && in_shell && !pci_write);
	cov_base_enable: cover property (!window_enable ##1 window_enable);
endmodule : pitic_window
